// ---- smspi_pkg.sv ----
/*
 * package for the serial memory spi front end: opcodes, status layout,
 * command classes and the header record handed to the memory core.
 * assumes: every user writes smspi_pkg::name, nothing is imported.
 */
package smspi_pkg;
   // ***************************************************************
   // opcodes
   // ***************************************************************
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_MEM_RD = 8'h03;
   localparam logic [7:0] OP_FAST_RD = 8'h0B;
   localparam logic [7:0] OP_MEM_WR = 8'h02;
   localparam logic [7:0] OP_SLEEP = 8'hB9;
   localparam logic [7:0] OP_ID_RD = 8'h9F;

   // ***************************************************************
   // sizes, positions, reset values
   // ***************************************************************
   localparam int ADDR_W = 14;
   localparam int MEM_DEPTH = 16384;
   localparam int LATCH_BIT = 1;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] STATUS_WR_MASK = 8'h8C;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ***************************************************************
   // command classes
   // ***************************************************************
   typedef enum logic [3:0] {
      SMSPI_CMD_NONE,
      SMSPI_CMD_SET_LATCH,
      SMSPI_CMD_CLR_LATCH,
      SMSPI_CMD_STAT_RD,
      SMSPI_CMD_STAT_WR,
      SMSPI_CMD_MEM_RD,
      SMSPI_CMD_FAST_RD,
      SMSPI_CMD_MEM_WR,
      SMSPI_CMD_SLEEP,
      SMSPI_CMD_ID_RD,
      SMSPI_CMD_BAD
   } smspi_cmd_t;

   typedef struct packed {
      smspi_cmd_t cmd;
      logic [ADDR_W-1:0] addr;
   } smspi_hdr_t;
endpackage

// ---- smspi_sync.sv ----
/*
 * two flip-flop synchroniser for one level.
 * assumes: input comes from outside the clock domain.
 */
`timescale 1ns/10ps
module smspi_sync #(
   // reset level matches the idle level of the pin
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

// ---- smspi_decode.sv ----
/*
 * opcode decoder: maps a received byte to a command class.
 * assumes: purely combinational, driven by the shifter of the top.
 */
`timescale 1ns/10ps
module smspi_decode (
   input wire logic [7:0] op_i,
   output smspi_pkg::smspi_cmd_t cmd_o
);
   always_comb begin
      case (op_i)
         smspi_pkg::OP_SET_LATCH: cmd_o = smspi_pkg::SMSPI_CMD_SET_LATCH;
         smspi_pkg::OP_CLR_LATCH: cmd_o = smspi_pkg::SMSPI_CMD_CLR_LATCH;
         smspi_pkg::OP_STAT_RD: cmd_o = smspi_pkg::SMSPI_CMD_STAT_RD;
         smspi_pkg::OP_STAT_WR: cmd_o = smspi_pkg::SMSPI_CMD_STAT_WR;
         smspi_pkg::OP_MEM_RD: cmd_o = smspi_pkg::SMSPI_CMD_MEM_RD;
         smspi_pkg::OP_FAST_RD: cmd_o = smspi_pkg::SMSPI_CMD_FAST_RD;
         smspi_pkg::OP_MEM_WR: cmd_o = smspi_pkg::SMSPI_CMD_MEM_WR;
         smspi_pkg::OP_SLEEP: cmd_o = smspi_pkg::SMSPI_CMD_SLEEP;
         smspi_pkg::OP_ID_RD: cmd_o = smspi_pkg::SMSPI_CMD_ID_RD;
         default: cmd_o = smspi_pkg::SMSPI_CMD_BAD;
      endcase
   end
endmodule

// ---- smspi_top.sv ----
/*
 * spi slave front end of a 16k x 8 serial memory: framing, mode capture,
 * msb-first shifting, opcode decode, address capture, write latch and
 * status register. pins are sampled on SYS_CLK_I after two flip-flops.
 * assumes: sck runs well below a quarter of SYS_CLK_I; memory core and
 * later byte phases are outside and fed through the header and byte ports.
 */
// Notes on behaviour
// - sample serial input on each rising clock edge after select falls.
// - serial output changes only on falling serial clock edges.
// - clock level at select fall picks mode 0 (low) or 3 (high).
// - in mode 3 the first rising edge after toggling samples first.
// - first eight bits are opcode, then address and data bytes.
// - each command starts at select fall; one opcode per select period.
// - with select high, input ignored and output high impedance.
// - all bytes move most significant bit first.
// - two address bytes; only the low 14 bits are kept.
// - unknown opcode: no action, ignore input until next select fall.
// - latch set 06h, latch clear 04h, status read 05h.
// - read 03h, fast read 0Bh, write 02h, status write 01h.
// - sleep B9h, id read 9Fh; nine opcodes in all.
// - write latch is clear after reset, writes disabled; code blocks status writes only, WR_BYTE_STB_O still fires for memory writes.
// - status write data never sets the latch; only latch set sets it.
// - latch cleared at select rise ending clear, status write or write.
// - after latch clear a status read shows the latch flag zero.
// - eight-bit status register holds a flag mirroring the latch.
// - writes finish at bus speed; the block never signals busy.
// - memory array has 16,384 individually addressed bytes.
// - write latch shows in status bit 1: one enabled, zero disabled.
`timescale 1ns/10ps
module smspi_top (
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic SPI_SCK_I,
   input wire logic SPI_CSN_I,
   input wire logic SPI_SI_I,
   output logic SPI_SO_O,
   output logic SPI_SO_OEN_O,
   input wire logic [7:0] RD_BYTE_I,
   output logic RD_BYTE_REQ_O,
   output logic [7:0] WR_BYTE_O,
   output logic WR_BYTE_STB_O,
   output smspi_pkg::smspi_hdr_t HDR_O,
   output logic HDR_STB_O,
   output logic [7:0] STATUS_O,
   output logic WRITE_LATCH_FLAG_O,
   output logic MODE3_O,
   output logic BUSY_O
);
   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic sck_s;
   logic csn_s;
   logic si_s;

   smspi_sync u_sync_sck (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RESETN_I),
      .d_i(SPI_SCK_I),
      .q_o(sck_s)
   );
   // select idles high: no false edge after reset
   smspi_sync #(.RST_VAL(1'b1)) u_sync_csn (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RESETN_I),
      .d_i(SPI_CSN_I),
      .q_o(csn_s)
   );
   smspi_sync u_sync_si (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RESETN_I),
      .d_i(SPI_SI_I),
      .q_o(si_s)
   );

   // ***************************************************************
   // edge detection
   // ***************************************************************
   logic sck_d;
   logic csn_d;
   logic csn_init;

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sck_d <= 1'b0;
         csn_d <= 1'b1;
         csn_init <= 1'b0;
      end else begin
         sck_d <= sck_s;
         csn_d <= csn_s;
         csn_init <= 1'b1;
      end
   end

   wire cs_fall = csn_init && csn_d && !csn_s;
   wire cs_rise = csn_init && !csn_d && csn_s;
   wire selected = !csn_s && !csn_d;
   wire sck_rise = selected && !sck_d && sck_s;
   wire sck_fall = selected && sck_d && !sck_s;

   // ***************************************************************
   // frame state
   // ***************************************************************
   typedef enum logic [2:0] {
      SMSPI_ST_IDLE,
      SMSPI_ST_OPCODE,
      SMSPI_ST_ADDR_HI,
      SMSPI_ST_ADDR_LO,
      SMSPI_ST_DATA,
      SMSPI_ST_IGNORE
   } smspi_state_t;

   smspi_state_t state;
   smspi_state_t next_state;
   smspi_pkg::smspi_cmd_t cmd;
   smspi_pkg::smspi_cmd_t dec_cmd;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   logic [7:0] addr_hi;
   logic mode3;
   logic [7:0] status_cfg;
   logic latch;
   logic [7:0] tx;
   logic so;
   logic so_oen;

   wire [7:0] next_byte = {shift[6:0], si_s};
   wire byte_done = sck_rise && (bit_cnt == smspi_pkg::BITS_PER_BYTE - 4'h1);
   wire hdr_cmd = (dec_cmd == smspi_pkg::SMSPI_CMD_MEM_RD) ||
                  (dec_cmd == smspi_pkg::SMSPI_CMD_FAST_RD) ||
                  (dec_cmd == smspi_pkg::SMSPI_CMD_MEM_WR);
   wire data_cmd = (dec_cmd == smspi_pkg::SMSPI_CMD_STAT_RD) ||
                   (dec_cmd == smspi_pkg::SMSPI_CMD_STAT_WR) ||
                   (dec_cmd == smspi_pkg::SMSPI_CMD_ID_RD);
   wire reads_out = (cmd == smspi_pkg::SMSPI_CMD_STAT_RD) ||
                    (cmd == smspi_pkg::SMSPI_CMD_MEM_RD) ||
                    (cmd == smspi_pkg::SMSPI_CMD_FAST_RD) ||
                    (cmd == smspi_pkg::SMSPI_CMD_ID_RD);
   wire [7:0] status_view = {status_cfg[7:2], latch, 1'b0};

   smspi_decode u_decode (
      .op_i(next_byte),
      .cmd_o(dec_cmd)
   );

   always_comb begin
      next_state = state;
      case (state)
         SMSPI_ST_IDLE: begin
            next_state = state;
         end
         SMSPI_ST_OPCODE: begin
            if (byte_done) begin
               if (dec_cmd == smspi_pkg::SMSPI_CMD_BAD) begin
                  next_state = SMSPI_ST_IGNORE;
               end else if (hdr_cmd) begin
                  next_state = SMSPI_ST_ADDR_HI;
               end else if (data_cmd) begin
                  next_state = SMSPI_ST_DATA;
               end else begin
                  next_state = SMSPI_ST_IGNORE;
               end
            end
         end
         SMSPI_ST_ADDR_HI: begin
            if (byte_done) begin
               next_state = SMSPI_ST_ADDR_LO;
            end
         end
         SMSPI_ST_ADDR_LO: begin
            if (byte_done) begin
               next_state = SMSPI_ST_DATA;
            end
         end
         SMSPI_ST_DATA: begin
            next_state = state;
         end
         SMSPI_ST_IGNORE: begin
            next_state = state;
         end
         default: begin
            next_state = SMSPI_ST_IDLE;
         end
      endcase
      if (cs_fall) begin
         next_state = SMSPI_ST_OPCODE;
      end else if (csn_s) begin
         next_state = SMSPI_ST_IDLE;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state <= SMSPI_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ***************************************************************
   // mode capture and bit shifter
   // ***************************************************************
   wire shifting = (state != SMSPI_ST_IDLE) && (state != SMSPI_ST_IGNORE);

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         mode3 <= 1'b0;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
      end else if (cs_fall) begin
         mode3 <= sck_s;
         bit_cnt <= 4'h0;
      end else if (shifting && sck_rise) begin
         // a mode 3 idle-high clock gives no rising edge until it toggles
         shift <= next_byte;
         bit_cnt <= byte_done ? 4'h0 : bit_cnt + 4'h1;
      end
   end

   // ***************************************************************
   // command, address and data bytes
   // ***************************************************************
   wire in_opcode = (state == SMSPI_ST_OPCODE) && byte_done;
   wire in_addr_lo = (state == SMSPI_ST_ADDR_LO) && byte_done;
   wire in_data = (state == SMSPI_ST_DATA) && byte_done;

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cmd <= smspi_pkg::SMSPI_CMD_NONE;
         addr_hi <= 8'h00;
         HDR_O <= '0;
         HDR_STB_O <= 1'b0;
         WR_BYTE_O <= 8'h00;
         WR_BYTE_STB_O <= 1'b0;
      end else begin
         HDR_STB_O <= 1'b0;
         WR_BYTE_STB_O <= 1'b0;
         if (cs_fall) begin
            cmd <= smspi_pkg::SMSPI_CMD_NONE;
         end else if (in_opcode) begin
            cmd <= dec_cmd;
         end
         if ((state == SMSPI_ST_ADDR_HI) && byte_done) begin
            addr_hi <= next_byte;
         end
         if (in_addr_lo) begin
            // upper two address bits dropped
            HDR_O <= {cmd, addr_hi[5:0], next_byte};
            HDR_STB_O <= 1'b1;
         end
         if (in_data && !reads_out) begin
            WR_BYTE_O <= next_byte;
            WR_BYTE_STB_O <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // write latch and status register
   // ***************************************************************
   wire stat_wr_ok = in_data && (cmd == smspi_pkg::SMSPI_CMD_STAT_WR) && latch;
   wire latch_set = cs_rise && (cmd == smspi_pkg::SMSPI_CMD_SET_LATCH);
   wire latch_clr = cs_rise && ((cmd == smspi_pkg::SMSPI_CMD_CLR_LATCH) ||
                                (cmd == smspi_pkg::SMSPI_CMD_STAT_WR) ||
                                (cmd == smspi_pkg::SMSPI_CMD_MEM_WR));

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         latch <= 1'b0;
         status_cfg <= smspi_pkg::STATUS_RST;
      end else begin
         if (latch_set) begin
            latch <= 1'b1;
         end else if (latch_clr) begin
            latch <= 1'b0;
         end
         if (stat_wr_ok) begin
            // only writable config bits; latch position masked off
            status_cfg <= next_byte & smspi_pkg::STATUS_WR_MASK;
         end
      end
   end

   // ***************************************************************
   // serial output
   // ***************************************************************
   wire out_active = (state == SMSPI_ST_DATA) && reads_out;
   wire load_tx = sck_fall && (bit_cnt == 4'h0);

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tx <= 8'h00;
         so <= 1'b0;
         so_oen <= 1'b1;
         RD_BYTE_REQ_O <= 1'b0;
      end else begin
         RD_BYTE_REQ_O <= 1'b0;
         if (!out_active) begin
            so_oen <= 1'b1;
         end else if (load_tx) begin
            so <= (cmd == smspi_pkg::SMSPI_CMD_STAT_RD) ? status_view[7] : RD_BYTE_I[7];
            tx <= (cmd == smspi_pkg::SMSPI_CMD_STAT_RD) ? {status_view[6:0], 1'b0} :
                  {RD_BYTE_I[6:0], 1'b0};
            so_oen <= 1'b0;
            RD_BYTE_REQ_O <= (cmd != smspi_pkg::SMSPI_CMD_STAT_RD);
         end else if (sck_fall) begin
            so <= tx[7];
            tx <= {tx[6:0], 1'b0};
         end
      end
   end

   assign SPI_SO_O = so;
   assign SPI_SO_OEN_O = so_oen;
   assign STATUS_O = status_view;
   assign WRITE_LATCH_FLAG_O = latch;
   assign MODE3_O = mode3;
   assign BUSY_O = 1'b0;
endmodule

// ---- smspi_monitor.sv ----
/*
 * checker for the serial memory spi front end, watching top-level ports only.
 * assumes: bound into every smspi_top instance by the bind at the foot.
 */
`timescale 1ns/10ps
module smspi_monitor (
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic SPI_SCK_I,
   input wire logic SPI_CSN_I,
   input wire logic SPI_SO_O,
   input wire logic SPI_SO_OEN_O,
   input wire logic WR_BYTE_STB_O,
   input wire smspi_pkg::smspi_hdr_t HDR_O,
   input wire logic HDR_STB_O,
   input wire logic [7:0] STATUS_O,
   input wire logic WRITE_LATCH_FLAG_O,
   input wire logic MODE3_O,
   input wire logic BUSY_O
);
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RESETN_I);
   // ***************************************************************
   // assertions and covers
   // ***************************************************************
   a_so_on_fall:
      assert property ($changed(SPI_SO_O) && !SPI_SO_OEN_O |-> !$past(SPI_SCK_I, 2))
      else $error("serial out moved outside the low clock phase");
   a_idle_hiz:
      assert property (SPI_CSN_I [*6] |-> SPI_SO_OEN_O)
      else $error("serial out driven while deselected");
   a_latch_at_rise:
      assert property ($changed(WRITE_LATCH_FLAG_O) |-> SPI_CSN_I && $past(SPI_CSN_I, 2))
      else $error("write latch moved inside a frame");
   a_status_mirror:
      assert property ($stable(WRITE_LATCH_FLAG_O) [*2] |-> STATUS_O[1] == WRITE_LATCH_FLAG_O)
      else $error("status bit 1 differs from write latch");
   a_fixed_zero:
      assert property (STATUS_O[0] == 1'b0 && STATUS_O[6:4] == 3'h0)
      else $error("fixed status bits not zero");
   a_never_busy:
      assert property (!BUSY_O)
      else $error("busy raised");
   a_hdr_cmd:
      assert property (HDR_STB_O |-> HDR_O.cmd inside {smspi_pkg::SMSPI_CMD_MEM_RD,
         smspi_pkg::SMSPI_CMD_FAST_RD, smspi_pkg::SMSPI_CMD_MEM_WR})
      else $error("header strobe for a command without address");
   a_hdr_in_frame:
      assert property (HDR_STB_O |-> !SPI_CSN_I ##1 !HDR_STB_O)
      else $error("header strobe outside frame or too long");
   a_wr_in_frame:
      assert property (WR_BYTE_STB_O |-> !SPI_CSN_I ##1 !WR_BYTE_STB_O)
      else $error("write byte strobe outside frame or too long");
   a_mode_held:
      assert property (!SPI_CSN_I [*8] |-> $stable(MODE3_O))
      else $error("mode changed inside a frame");
   c_mem_wr: cover property (HDR_STB_O && HDR_O.cmd == smspi_pkg::SMSPI_CMD_MEM_WR);
   c_mode3_read: cover property (MODE3_O && !SPI_SO_OEN_O);
   c_latch_clear: cover property ($fell(WRITE_LATCH_FLAG_O));
endmodule

bind smspi_top smspi_monitor u_smspi_monitor (
   .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .SPI_SCK_I(SPI_SCK_I),
   .SPI_CSN_I(SPI_CSN_I), .SPI_SO_O(SPI_SO_O), .SPI_SO_OEN_O(SPI_SO_OEN_O),
   .WR_BYTE_STB_O(WR_BYTE_STB_O), .HDR_O(HDR_O), .HDR_STB_O(HDR_STB_O),
   .STATUS_O(STATUS_O), .WRITE_LATCH_FLAG_O(WRITE_LATCH_FLAG_O), .MODE3_O(MODE3_O),
   .BUSY_O(BUSY_O)
);

// ---- smspi_master_model.sv ----
/*
 * behavioural spi master: frames, mode 0 or 3, msb-first bytes.
 * assumes: clk_i is the system clock; all pins move on its falling edge.
 */
`timescale 1ns/10ps
module smspi_master_model (
   input wire logic clk_i,
   input wire logic so_i,
   output logic sck_o,
   output logic csn_o,
   output logic si_o
);
   logic m3_q;
   // ***************************************************************
   // frame tasks
   // ***************************************************************
   initial begin
      sck_o = 1'b0;
      csn_o = 1'b1;
      si_o = 1'b0;
      m3_q = 1'b0;
   end
   // half of a 320 ns link clock period
   task automatic half();
      repeat (4) @(negedge clk_i);
   endtask
   task automatic start(input logic m3);
      m3_q = m3;
      sck_o = m3;
      half();
      half();
      csn_o = 1'b0;
      half();
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck_o = 1'b0;
         si_o = tx[i];
         half();
         sck_o = 1'b1;
         half();
         rx[i] = so_i;
      end
   endtask
   task automatic stop();
      if (!m3_q) begin
         sck_o = 1'b0;
         half();
      end
      csn_o = 1'b1;
      si_o = ~si_o;
      half();
      half();
   endtask
endmodule

// ---- tb.sv ----
/*
 * self-checking bench for smspi_top driven by the spi master model.
 * assumes: 25 MHz system clock, link clock from the model at 320 ns.
 */
`timescale 1ns/10ps
module tb;
   logic clk, rstn, sck, csn, si, so, so_oen, so_wire, rd_req, wr_stb, hdr_stb;
   logic latch, mode3, busy;
   logic [7:0] rd_byte, wr_byte, status, wr_seen, rx;
   smspi_pkg::smspi_hdr_t hdr, hdr_seen;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   int hdr_cnt = 0;
   int wr_cnt = 0;
   int oen_cnt = 0;
   int rq_cnt = 0;
   int ch, cw, co, cr;
   logic [7:0] bad_ops[6] = '{8'hC3, 8'hC2, 8'h5A, 8'h5B, smspi_pkg::OP_SLEEP, 8'hFF};
   logic [7:0] rd_ops[2] = '{smspi_pkg::OP_MEM_RD, smspi_pkg::OP_FAST_RD};
   smspi_pkg::smspi_cmd_t rd_cmds[2] = '{smspi_pkg::SMSPI_CMD_MEM_RD,
      smspi_pkg::SMSPI_CMD_FAST_RD};
   // ***************************************************************
   // clock, design, partner, observers
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   assign so_wire = so_oen ? 1'bz : so;
   smspi_top u_smspi_top (.SYS_CLK_I(clk), .RESETN_I(rstn), .SPI_SCK_I(sck), .SPI_CSN_I(csn),
      .SPI_SI_I(si), .SPI_SO_O(so), .SPI_SO_OEN_O(so_oen), .RD_BYTE_I(rd_byte),
      .RD_BYTE_REQ_O(rd_req), .WR_BYTE_O(wr_byte), .WR_BYTE_STB_O(wr_stb), .HDR_O(hdr),
      .HDR_STB_O(hdr_stb), .STATUS_O(status), .WRITE_LATCH_FLAG_O(latch), .MODE3_O(mode3),
      .BUSY_O(busy));
   smspi_master_model u_smspi_master_model (.clk_i(clk), .so_i(so_wire), .sck_o(sck),
      .csn_o(csn), .si_o(si));
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (hdr_stb === 1'b1) begin
         hdr_seen <= hdr;
         hdr_cnt <= hdr_cnt + 1;
      end
      if (wr_stb === 1'b1) begin
         wr_seen <= wr_byte;
         wr_cnt <= wr_cnt + 1;
      end
      if (so_oen === 1'b0) begin
         oen_cnt <= oen_cnt + 1;
      end
      if (rd_req === 1'b1) begin
         rq_cnt <= rq_cnt + 1;
      end
   end
   always @(negedge clk) begin
      if (cycles == 20000) begin
         n_fail++;
         $display("ERROR timeout expected finish seen hang");
         summarize();
      end
   end
   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic frame(input logic m3, input logic [7:0] tx[$]);
      u_smspi_master_model.start(m3);
      foreach (tx[i]) u_smspi_master_model.xfer(tx[i], rx);
      u_smspi_master_model.stop();
   endtask
   task automatic stat_rd(input logic [7:0] exp);
      frame(1'b0, '{smspi_pkg::OP_STAT_RD, 8'h00});
      chk("status_read", exp, rx);
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      rstn = 1'b0;
      rd_byte = 8'h96;
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      chk("latch", 1'b0, latch);
      chk("so_oen", 1'b1, so_oen);
      chk("busy", 1'b0, busy);
      $display("test reset done");
      frame(1'b0, '{smspi_pkg::OP_SET_LATCH});
      chk("latch", 1'b1, latch);
      stat_rd(8'h02);
      frame(1'b0, '{smspi_pkg::OP_CLR_LATCH});
      stat_rd(8'h00);
      $display("test latch done");
      frame(1'b0, '{smspi_pkg::OP_SET_LATCH});
      frame(1'b0, '{smspi_pkg::OP_STAT_WR, 8'hFF});
      chk("wr_byte", 8'hFF, wr_seen);
      chk("latch", 1'b0, latch);
      chk("status", 8'h8C, status);
      // latch clear, so this write is ignored
      frame(1'b0, '{smspi_pkg::OP_STAT_WR, 8'h00});
      chk("status", 8'h8C, status);
      frame(1'b1, '{smspi_pkg::OP_SET_LATCH});
      frame(1'b1, '{smspi_pkg::OP_STAT_WR, 8'h00});
      chk("status", 8'h00, status);
      $display("test status write done");
      frame(1'b0, '{smspi_pkg::OP_SET_LATCH});
      frame(1'b1, '{smspi_pkg::OP_MEM_WR, 8'hC1, 8'h23, 8'hA5});
      chk("mode3", 1'b1, mode3);
      chk("hdr", {smspi_pkg::SMSPI_CMD_MEM_WR, 14'h0123}, hdr_seen);
      chk("wr_byte", 8'hA5, wr_seen);
      chk("latch", 1'b0, latch);
      $display("test write done");
      cr = rq_cnt;
      for (int i = 0; i < 2; i++) begin
         frame(i[0], '{rd_ops[i], 8'hFF, 8'hFF, 8'h00});
         chk("mode3", i[0], mode3);
         chk("hdr", {rd_cmds[i], 14'h3FFF}, hdr_seen);
         chk("read_byte", 8'h96, rx);
      end
      // mode 0 ends on a falling edge at a byte boundary: one extra byte taken
      chk("rd_req_count", 18'(cr + 3), 18'(rq_cnt));
      frame(1'b0, '{smspi_pkg::OP_MEM_RD, 8'h00, 8'h05, 8'h00});
      chk("hdr", {smspi_pkg::SMSPI_CMD_MEM_RD, 14'h0005}, hdr_seen);
      frame(1'b0, '{smspi_pkg::OP_ID_RD, 8'h00});
      chk("id_byte", 8'h96, rx);
      $display("test read done");
      frame(1'b0, '{smspi_pkg::OP_SET_LATCH});
      ch = hdr_cnt;
      cw = wr_cnt;
      co = oen_cnt;
      cr = rq_cnt;
      foreach (bad_ops[i]) begin
         frame(i[0], '{bad_ops[i], 8'h04, 8'h02, 8'h00, 8'h00, 8'hA5});
      end
      chk("hdr_count", 18'(ch), 18'(hdr_cnt));
      chk("wr_count", 18'(cw), 18'(wr_cnt));
      chk("oen_count", 18'(co), 18'(oen_cnt));
      chk("rd_req_count", 18'(cr), 18'(rq_cnt));
      chk("latch", 1'b1, latch);
      $display("test bad opcode done");
      summarize();
   end
endmodule
